// File: logic/mdu_device.sv
// How it works
// - operand byte 0 write opens loading
// - byte 5 or control write launches operation
// - byte 2/3 written selects 32/16 divide
// - byte 4 last: 16/16 divide; byte 1: multiply
// - runs alone, core never stalled
// - latencies 17, 9, 11 cycles
// - shift 3..18, normalise 4..19 cycles
// - results placed in bytes per operation
// - final byte read ends the calculation
// - normalise left, count into control bits 4:0
// - bit 5 direction, bits 4:0 count
// - shifts fill with zeros
// - error detection from byte 0 to final read
// - write during execution sets error
// - byte register read during execution sets error, continues
// - error cleared only by control read
// - overflow: divide zero, big product, normalised
// - other operations clear overflow
// - overflow not writable by software
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mdu_device
   import mdu_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   mdu_link_if.dev    link,
   output logic       err_flag,
   output logic       ov_flag
);
   logic [7:0]    md_q [NBYTES];
   mdu_phase_type phase_q;
   mdu_op_type    op_q;
   logic [5:0]    lat_q;
   logic          div32_q;
   logic          last_md1_q;
   logic          detect_q;
   logic          err_q;
   logic          ov_q;
   logic          dir_q;
   logic [4:0]    cnt_q;
   logic [7:0]    rdata_q;

   logic          launch;
   mdu_op_type    launch_op;
   logic          complete;
   logic          final_rd;
   logic          err_set;
   logic [31:0]   a32;
   logic [15:0]   a16;
   logic [15:0]   b16;
   logic [31:0]   res32;
   logic [15:0]   rem16;
   logic [31:0]   prod;
   logic          ov_d;
   logic [4:0]    nc;

   function automatic logic [4:0] lead_zeros(logic [31:0] v);
      logic [4:0] n;
      n = 5'h1F;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            n = 5'(31 - i);
         end
      end
      return n;
   endfunction

   function automatic logic [5:0] latency(mdu_op_type op, logic [4:0] cnt);
      logic [5:0] half;
      half = (cnt == 5'h00) ? 6'h00 : {2'h0, 4'((cnt - 5'h01) >> 1)};
      case (op)
         OP_DIV32: return LAT_DIV32;
         OP_DIV16: return LAT_DIV16;
         OP_MUL:   return LAT_MUL;
         OP_SHIFT: return LAT_SHIFT_BASE + half;
         default:  return LAT_NORM_BASE + half;
      endcase
   endfunction

   assign a32 = {md_q[3], md_q[2], md_q[1], md_q[0]};
   assign a16 = {md_q[1], md_q[0]};
   assign b16 = {md_q[5], md_q[4]};
   assign nc  = a32[31] ? 5'h00 : lead_zeros(a32);
   assign prod = a16 * b16;

   // launch decode
   always_comb begin
      launch    = 1'b0;
      launch_op = OP_MUL;
      if (link.wr && (phase_q == PH_LOAD || phase_q == PH_EXEC)) begin
         if (link.addr == ADDR_B5) begin
            launch = 1'b1;
            if (div32_q) begin
               launch_op = OP_DIV32;
            end else if (last_md1_q) begin
               launch_op = OP_MUL;
            end else begin
               launch_op = OP_DIV16;
            end
         end else if (link.addr == ADDR_CTRL) begin
            launch    = 1'b1;
            // a zero count is not a legal shift, so it means normalise
            launch_op = (link.wdata[4:0] == 5'h00) ? OP_NORM : OP_SHIFT;
         end
      end
   end

   assign complete = (phase_q == PH_EXEC) && (lat_q == 6'h01) && !link.wr;
   assign final_rd = link.rd && (phase_q == PH_RESULT)
                     && (link.addr == (mdu_is_div(op_q) ? ADDR_B5 : ADDR_B3));

   // result arithmetic, sampled at completion
   always_comb begin
      res32 = a32;
      rem16 = b16;
      ov_d  = 1'b0;
      case (op_q)
         OP_DIV32: begin
            if (b16 == 16'h0000) begin
               ov_d = 1'b1;
            end else begin
               res32 = a32 / {16'h0000, b16};
               rem16 = 16'(a32 % {16'h0000, b16});
            end
         end
         OP_DIV16: begin
            if (b16 == 16'h0000) begin
               ov_d = 1'b1;
            end else begin
               res32 = {a32[31:16], a16 / b16};
               rem16 = a16 % b16;
            end
         end
         OP_MUL: begin
            res32 = prod;
            ov_d  = prod[31:16] != 16'h0000;
         end
         OP_SHIFT: begin
            res32 = dir_q ? (a32 >> cnt_q) : (a32 << cnt_q);
         end
         default: begin
            res32 = a32 << nc;
            ov_d  = a32[31];
         end
      endcase
   end

   // phase sequencing; busy never holds off the link
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= PH_IDLE;
         op_q    <= OP_MUL;
         lat_q   <= 6'h00;
      end else if (launch) begin
         phase_q <= PH_EXEC;
         op_q    <= launch_op;
         lat_q   <= latency(launch_op, (launch_op == OP_NORM) ? nc : link.wdata[4:0]);
      end else if (link.wr && (link.addr == ADDR_B0 || phase_q == PH_EXEC)) begin
         phase_q <= PH_LOAD;
      end else if (phase_q == PH_EXEC) begin
         if (lat_q == 6'h01) begin
            phase_q <= PH_RESULT;
         end else begin
            lat_q <= lat_q - 6'h01;
         end
      end else if (final_rd) begin
         phase_q <= PH_IDLE;
      end
   end

   // operation selection by write order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div32_q    <= 1'b0;
         last_md1_q <= 1'b0;
      end else if (link.wr) begin
         if (link.addr == ADDR_B0) begin
            div32_q    <= 1'b0;
            last_md1_q <= 1'b0;
         end else if (link.addr == ADDR_B2 || link.addr == ADDR_B3) begin
            div32_q <= 1'b1;
         end else if (link.addr == ADDR_B1) begin
            last_md1_q <= 1'b1;
         end else if (link.addr == ADDR_B4) begin
            last_md1_q <= 1'b0;
         end
      end
   end

   // operand and result bytes; a write aborts a completion in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NBYTES; i++) begin
            md_q[i] <= BYTE_RST;
         end
      end else if (link.wr && link.addr < ADDR_CTRL) begin
         md_q[link.addr] <= link.wdata;
      end else if (complete) begin
         for (int i = 0; i < 4; i++) begin
            md_q[i] <= res32[8*i +: 8];
         end
         if (mdu_is_div(op_q)) begin
            md_q[4] <= rem16[7:0];
            md_q[5] <= rem16[15:8];
         end
      end
   end

   // control fields and overflow
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= 1'b0;
         cnt_q <= 5'h00;
         ov_q  <= 1'b0;
      end else if (link.wr && link.addr == ADDR_CTRL) begin
         dir_q <= link.wdata[DIR_BIT];
         cnt_q <= link.wdata[4:0];
      end else if (complete) begin
         ov_q <= ov_d;
         if (op_q == OP_NORM) begin
            cnt_q <= nc;
         end
      end
   end

   // error detection window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         detect_q <= 1'b0;
      end else if (link.wr && link.addr == ADDR_B0) begin
         detect_q <= 1'b1;
      end else if (final_rd) begin
         detect_q <= 1'b0;
      end
   end

   assign err_set = (phase_q == PH_EXEC)
                    && (link.wr || (link.rd && detect_q && link.addr < ADDR_CTRL));

   // set beats the clearing control read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_q <= 1'b0;
      end else if (err_set) begin
         err_q <= 1'b1;
      end else if (link.rd && link.addr == ADDR_CTRL) begin
         err_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (link.rd) begin
         if (link.addr < ADDR_CTRL) begin
            rdata_q <= md_q[link.addr];
         end else if (link.addr == ADDR_CTRL) begin
            rdata_q <= {err_q, ov_q, dir_q, cnt_q};
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign link.rdata = rdata_q;
   assign link.busy  = (phase_q == PH_EXEC);
   assign err_flag   = err_q;
   assign ov_flag    = ov_q;
endmodule
`default_nettype wire

// File: logic/mdu_host.sv
`timescale 1ns/1ps
`default_nettype none
module mdu_host
   import mdu_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   mdu_link_if.host         link
);
   mdu_host_type st_q;
   mdu_op_type   op_q;
   logic [31:0]  opa_q;
   logic [15:0]  opb_q;
   logic         dir_q;
   logic [4:0]   shc_q;
   logic [31:0]  resq_q;
   logic [15:0]  resr_q;
   logic         done_q;
   logic         err_q;
   logic         ov_q;
   logic [4:0]   nc_q;
   logic [2:0]   step_q;
   logic         wr_q;
   logic         rd_q;
   logic [2:0]   addr_q;
   logic [7:0]   wdata_q;
   logic         cap_q;
   logic [2:0]   cap_addr_q;
   logic [31:0]  prdata_q;

   logic         mapped;
   logic         start;
   logic         bad_cmd;
   logic [20:0]  wseq;
   logic [2:0]   wlen;
   logic [20:0]  rseq;
   logic [2:0]   rlen;
   logic [2:0]   wa;
   logic [2:0]   ra;
   logic [7:0]   wbyte;

   // every transfer completes in its first access cycle
   assign pready  = 1'b1;
   assign mapped  = paddr == APB_CMD || paddr == APB_OPA || paddr == APB_OPB
                    || paddr == APB_RESQ || paddr == APB_RESR || paddr == APB_STATUS;
   assign bad_cmd = pwrite && paddr == APB_CMD && (st_q != H_IDLE || pwdata[2:0] > 3'h4);
   assign pslverr = psel && penable && (!mapped || bad_cmd);
   assign start   = psel && penable && pwrite && paddr == APB_CMD && !bad_cmd;

   always_comb begin
      case (op_q)
         OP_MUL:   wseq = SEQ_WR_MUL;
         OP_DIV16: wseq = SEQ_WR_DIV16;
         OP_DIV32: wseq = SEQ_WR_DIV32;
         default:  wseq = SEQ_WR_SHN;
      endcase
      wlen  = (op_q == OP_DIV32) ? 3'h6 : (op_q == OP_SHIFT || op_q == OP_NORM) ? 3'h5 : 3'h4;
      rseq  = mdu_is_div(op_q) ? SEQ_RD_DIV : SEQ_RD_OTHER;
      rlen  = mdu_is_div(op_q) ? 3'h7 : 3'h5;
      wa    = wseq[3*step_q +: 3];
      ra    = rseq[3*step_q +: 3];
      // normalise is asked for with a zero count
      case (wa)
         ADDR_B0: wbyte = opa_q[7:0];
         ADDR_B1: wbyte = opa_q[15:8];
         ADDR_B2: wbyte = opa_q[23:16];
         ADDR_B3: wbyte = opa_q[31:24];
         ADDR_B4: wbyte = opb_q[7:0];
         ADDR_B5: wbyte = opb_q[15:8];
         default: wbyte = {2'h0, dir_q, (op_q == OP_NORM) ? 5'h00 : shc_q};
      endcase
   end

   // operand and command registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opa_q <= 32'h0000_0000;
         opb_q <= 16'h0000;
         op_q  <= OP_MUL;
         dir_q <= 1'b0;
         shc_q <= 5'h00;
      end else if (psel && penable && pwrite) begin
         if (paddr == APB_OPA) begin
            opa_q <= pwdata;
         end else if (paddr == APB_OPB) begin
            opb_q <= pwdata[15:0];
         end else if (start) begin
            op_q  <= mdu_op_type'(pwdata[2:0]);
            dir_q <= pwdata[3];
            shc_q <= pwdata[8:4];
         end
      end
   end

   // load, wait and unload sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= H_IDLE;
         step_q  <= 3'h0;
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         addr_q  <= 3'h0;
         wdata_q <= 8'h00;
      end else begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         case (st_q)
            H_IDLE: begin
               step_q <= 3'h0;
               if (start) begin
                  st_q <= H_WRITE;
               end
            end
            H_WRITE: begin
               wr_q    <= 1'b1;
               addr_q  <= wa;
               wdata_q <= wbyte;
               step_q  <= step_q + 3'h1;
               if (step_q == wlen - 3'h1) begin
                  st_q <= H_WAIT_HI;
               end
            end
            H_WAIT_HI: begin
               step_q <= 3'h0;
               if (link.busy) begin
                  st_q <= H_WAIT_LO;
               end
            end
            H_WAIT_LO: begin
               // no access while busy, so the error flag stays clean
               if (!link.busy) begin
                  st_q <= H_READ;
               end
            end
            H_READ: begin
               rd_q   <= 1'b1;
               addr_q <= ra;
               step_q <= step_q + 3'h1;
               if (step_q == rlen - 3'h1) begin
                  st_q <= H_DRAIN;
               end
            end
            default: begin
               if (cap_q && !rd_q) begin
                  st_q <= H_IDLE;
               end
            end
         endcase
      end
   end

   // read data arrives one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_q      <= 1'b0;
         cap_addr_q <= 3'h0;
         resq_q     <= 32'h0000_0000;
         resr_q     <= 16'h0000;
         err_q      <= 1'b0;
         ov_q       <= 1'b0;
         nc_q       <= 5'h00;
      end else begin
         cap_q      <= rd_q;
         cap_addr_q <= addr_q;
         if (cap_q) begin
            if (cap_addr_q < ADDR_B4) begin
               resq_q[8*cap_addr_q +: 8] <= link.rdata;
            end else if (cap_addr_q == ADDR_B4) begin
               resr_q[7:0] <= link.rdata;
            end else if (cap_addr_q == ADDR_B5) begin
               resr_q[15:8] <= link.rdata;
            end else begin
               err_q <= link.rdata[ERR_BIT];
               ov_q  <= link.rdata[OV_BIT];
               nc_q  <= link.rdata[4:0];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else if (start) begin
         done_q <= 1'b0;
      end else if (st_q == H_DRAIN && cap_q && !rd_q) begin
         done_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable) begin
         if (paddr == APB_CMD) begin
            prdata_q <= {23'h000000, shc_q, dir_q, op_q};
         end else if (paddr == APB_OPA) begin
            prdata_q <= opa_q;
         end else if (paddr == APB_OPB) begin
            prdata_q <= {16'h0000, opb_q};
         end else if (paddr == APB_RESQ) begin
            prdata_q <= resq_q;
         end else if (paddr == APB_RESR) begin
            prdata_q <= {16'h0000, resr_q};
         end else if (paddr == APB_STATUS) begin
            prdata_q <= {23'h000000, nc_q, ov_q, err_q, done_q, st_q != H_IDLE};
         end else begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   assign prdata     = prdata_q;
   assign link.wr    = wr_q;
   assign link.rd    = rd_q;
   assign link.addr  = addr_q;
   assign link.wdata = wdata_q;
endmodule
`default_nettype wire

// File: logic/mdu_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mdu_link_if;
   logic       wr;
   logic       rd;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       busy;
   modport dev  (input wr, rd, addr, wdata, output rdata, busy);
   modport host (output wr, rd, addr, wdata, input rdata, busy);
endinterface
`default_nettype wire

// File: logic/mdu_pkg.sv
`default_nettype none
package mdu_pkg;
   // link addresses of the device registers
   localparam logic [2:0] ADDR_B0   = 3'h0;
   localparam logic [2:0] ADDR_B1   = 3'h1;
   localparam logic [2:0] ADDR_B2   = 3'h2;
   localparam logic [2:0] ADDR_B3   = 3'h3;
   localparam logic [2:0] ADDR_B4   = 3'h4;
   localparam logic [2:0] ADDR_B5   = 3'h5;
   localparam logic [2:0] ADDR_CTRL = 3'h6;
   localparam int         NBYTES    = 6;
   // arith_control_reg fields
   localparam int ERR_BIT = 7;
   localparam int OV_BIT  = 6;
   localparam int DIR_BIT = 5;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // execution latencies in clock cycles
   localparam logic [5:0] LAT_DIV32      = 6'h11;
   localparam logic [5:0] LAT_DIV16      = 6'h09;
   localparam logic [5:0] LAT_MUL        = 6'h0B;
   localparam logic [5:0] LAT_SHIFT_BASE = 6'h03;
   localparam logic [5:0] LAT_NORM_BASE  = 6'h04;
   // host load and unload orders, lowest field first
   localparam logic [20:0] SEQ_WR_MUL   = {9'h000, ADDR_B5, ADDR_B1, ADDR_B4, ADDR_B0};
   localparam logic [20:0] SEQ_WR_DIV16 = {9'h000, ADDR_B5, ADDR_B4, ADDR_B1, ADDR_B0};
   localparam logic [20:0] SEQ_WR_DIV32 = {3'h0, ADDR_B5, ADDR_B4, ADDR_B3, ADDR_B2, ADDR_B1, ADDR_B0};
   localparam logic [20:0] SEQ_WR_SHN   = {6'h00, ADDR_CTRL, ADDR_B3, ADDR_B2, ADDR_B1, ADDR_B0};
   localparam logic [20:0] SEQ_RD_DIV   = {ADDR_CTRL, ADDR_B5, ADDR_B4, ADDR_B3, ADDR_B2, ADDR_B1, ADDR_B0};
   localparam logic [20:0] SEQ_RD_OTHER = {6'h00, ADDR_CTRL, ADDR_B3, ADDR_B2, ADDR_B1, ADDR_B0};
   // host APB register offsets
   localparam logic [7:0] APB_CMD    = 8'h00;
   localparam logic [7:0] APB_OPA    = 8'h04;
   localparam logic [7:0] APB_OPB    = 8'h08;
   localparam logic [7:0] APB_RESQ   = 8'h0C;
   localparam logic [7:0] APB_RESR   = 8'h10;
   localparam logic [7:0] APB_STATUS = 8'h14;

   typedef enum logic [2:0] {OP_MUL, OP_DIV16, OP_DIV32, OP_SHIFT, OP_NORM} mdu_op_type;
   typedef enum logic [1:0] {PH_IDLE, PH_LOAD, PH_EXEC, PH_RESULT} mdu_phase_type;
   typedef enum logic [2:0] {H_IDLE, H_WRITE, H_WAIT_HI, H_WAIT_LO, H_READ, H_DRAIN} mdu_host_type;

   function automatic logic mdu_is_div(mdu_op_type op);
      return (op == OP_DIV16) || (op == OP_DIV32);
   endfunction
endpackage
`default_nettype wire

// File: verif/mdu_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mdu_link_monitor
   import mdu_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       busy,
   input wire logic       err_flag,
   input wire logic       ov_flag
);
   logic       ld_q, s23_q, mul_q, nrm_q;
   logic [5:0] cnt_q, exp_q;
   logic       launch;
   assign launch = wr && ld_q && (addr == ADDR_B5 || addr == ADDR_CTRL);
   // operation inferred from write order, the same way the device must
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ld_q  <= 1'b0;
         s23_q <= 1'b0;
         mul_q <= 1'b0;
      end else if (wr) begin
         if (addr == ADDR_B0) ld_q <= 1'b1;
         else if (launch) ld_q <= 1'b0;
         if (addr == ADDR_B0) s23_q <= 1'b0;
         else if (addr == ADDR_B2 || addr == ADDR_B3) s23_q <= 1'b1;
         if (addr == ADDR_B1) mul_q <= 1'b1;
         else if (addr == ADDR_B4) mul_q <= 1'b0;
      end
   end
   // normalise length depends on data, so only its range is held
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 6'h00;
         exp_q <= 6'h00;
         nrm_q <= 1'b0;
      end else if (launch) begin
         cnt_q <= 6'h00;
         nrm_q <= addr == ADDR_CTRL && wdata[4:0] == 5'h00;
         if (addr == ADDR_CTRL) exp_q <= LAT_SHIFT_BASE + 6'((wdata[4:0] - 5'h01) >> 1);
         else if (s23_q) exp_q <= LAT_DIV32;
         else if (mul_q) exp_q <= LAT_MUL;
         else exp_q <= LAT_DIV16;
      end else if (busy) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   load_first_a: assert property (wr && addr != ADDR_B0 |-> ld_q)
      else $error("write before operand byte 0");
   launch_busy_a: assert property (launch && !busy |=> busy)
      else $error("launch did not start execution");
   busy_cause_a: assert property ($rose(busy) |-> $past(launch))
      else $error("busy without launch");
   op_latency_a: assert property ($fell(busy) |-> (nrm_q ? (cnt_q >= 6'h04 && cnt_q <= 6'h13) : cnt_q == exp_q))
      else $error("wrong execution length");
   busy_min_a: assert property ($rose(busy) |-> busy [*3])
      else $error("execution shorter than three cycles");
   err_quiet_a: assert property (!(busy && (wr || rd)) && !(rd && addr == ADDR_CTRL) |=> $stable(err_flag))
      else $error("error flag changed without cause");
   ov_calc_a: assert property (!$fell(busy) |-> $stable(ov_flag))
      else $error("overflow changed outside completion");
   rdata_hold_a: assert property (!rd |=> $stable(rdata))
      else $error("read data changed without read");
   cover property (launch && s23_q);
   cover property (launch && addr == ADDR_CTRL);
   cover property ($fell(busy) && nrm_q);
endmodule
`default_nettype wire

// File: verif/multiply_divide_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module multiply_divide_unit_test
   import mdu_pkg::*;
;
   typedef struct packed {
      logic [8:0]  cmd;
      logic [31:0] a;
      logic [15:0] b;
      logic [31:0] q;
      logic [31:0] m;
      logic [15:0] r;
      logic        ov;
   } mdu_case_type;
   localparam mdu_case_type CASES [9] = '{
      '{9'h000, 32'h00001234, 16'h0100, 32'h00123400, 32'hFFFFFFFF, 16'h0000, 1'b1},
      '{9'h000, 32'h000000FF, 16'h0101, 32'h0000FFFF, 32'hFFFFFFFF, 16'h0000, 1'b0},
      '{9'h002, 32'h12345678, 16'h0100, 32'h00123456, 32'hFFFFFFFF, 16'h0078, 1'b0},
      '{9'h001, 32'h00001234, 16'h0010, 32'h00000123, 32'h0000FFFF, 16'h0004, 1'b0},
      '{9'h001, 32'h00001234, 16'h0000, 32'h00000000, 32'h00000000, 16'h0000, 1'b1},
      '{9'h043, 32'h0F000001, 16'h0000, 32'hF0000010, 32'hFFFFFFFF, 16'h0000, 1'b0},
      '{9'h1FB, 32'h80000000, 16'h0000, 32'h00000001, 32'hFFFFFFFF, 16'h0000, 1'b0},
      '{9'h004, 32'h80000001, 16'h0000, 32'h80000001, 32'hFFFFFFFF, 16'h0000, 1'b1},
      '{9'h004, 32'h00010000, 16'h0000, 32'h80000000, 32'hFFFFFFFF, 16'h0000, 1'b0}};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  paddr;
   logic        psel, penable, pwrite, pready, pslverr, e;
   logic [31:0] pwdata, prdata, q;
   logic        err_flag, ov_flag, err2, ov2;
   int          err_count, n_tests, cyc;
   mdu_link_if link_if ();
   mdu_link_if fault_if ();
   mdu_host mdu_host_inst (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if.host));
   mdu_device mdu_device_inst (.clk(clk), .rst_n(rst_n), .link(link_if.dev), .err_flag(err_flag), .ov_flag(ov_flag));
   // second device faces the bench, which breaks the access rules on purpose
   mdu_device mdu_device_inst_f (.clk(clk), .rst_n(rst_n), .link(fault_if.dev), .err_flag(err2), .ov_flag(ov2));
   mdu_link_monitor mdu_link_monitor_inst (.clk(clk), .rst_n(rst_n), .wr(link_if.wr), .rd(link_if.rd),
      .addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata), .busy(link_if.busy),
      .err_flag(err_flag), .ov_flag(ov_flag));
   always #10 clk = ~clk;
   task automatic give_verdict();
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic lacc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      fault_if.wr <= w;
      fault_if.rd <= !w;
      fault_if.addr <= a;
      fault_if.wdata <= d;
      @(posedge clk);
      fault_if.wr <= 1'b0;
      fault_if.rd <= 1'b0;
      #1;
   endtask
   task automatic run(input mdu_case_type c);
      apb(1'b1, APB_OPA, c.a);
      apb(1'b1, APB_OPB, {16'h0000, c.b});
      apb(1'b1, APB_CMD, {23'h000000, c.cmd});
      do apb(1'b0, APB_STATUS, 32'h00000000); while (q[1] !== 1'b1);
      check("overflow", 32'(q[3]), 32'(c.ov));
      check("error", 32'(q[2]), 32'h00000000);
      apb(1'b0, APB_RESQ, 32'h00000000);
      check("result", q & c.m, c.q);
      if (c.cmd[2:0] == 3'h2 || (c.cmd[2:0] == 3'h1 && c.b != 16'h0000)) begin
         apb(1'b0, APB_RESR, 32'h00000000);
         check("remainder", q, {16'h0000, c.r});
      end
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {fault_if.wr, fault_if.rd, fault_if.addr, fault_if.wdata} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, APB_STATUS, 32'h00000000);
      check("status reset", q, 32'h00000000);
      foreach (CASES[i]) run(CASES[i]);
      apb(1'b0, APB_STATUS, 32'h00000000);
      check("norm count", 32'(q[8:4]), 32'h0000000F);
      apb(1'b0, 8'h18, 32'h00000000);
      check("unmapped", {q[30:0], e}, 32'h00000001);
      apb(1'b1, APB_CMD, 32'h00000005);
      check("bad op", 32'(e), 32'h00000001);
      // 3 x 4 with an early read: flagged but still completes
      lacc(1'b1, ADDR_B0, 8'h03);
      lacc(1'b1, ADDR_B4, 8'h04);
      lacc(1'b1, ADDR_B1, 8'h00);
      lacc(1'b1, ADDR_B5, 8'h00);
      lacc(1'b0, ADDR_B0, 8'h00);
      check("early read err", 32'(err2), 32'h00000001);
      check("still busy", 32'(fault_if.busy), 32'h00000001);
      while (fault_if.busy === 1'b1) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         lacc(1'b0, 3'(k), 8'h00);
         check("product byte", 32'(fault_if.rdata), 32'(8'(32'h0000000C >> (8 * k))));
      end
      lacc(1'b0, ADDR_CTRL, 8'h00);
      check("ctrl err bit", 32'(fault_if.rdata[ERR_BIT]), 32'h00000001);
      check("err cleared", 32'(err2), 32'h00000000);
      lacc(1'b1, ADDR_CTRL, 8'h40);
      check("ov unwritable", 32'(ov2), 32'h00000000);
      lacc(1'b1, ADDR_B0, 8'h03);
      lacc(1'b1, ADDR_B4, 8'h04);
      lacc(1'b1, ADDR_B1, 8'h00);
      lacc(1'b1, ADDR_B5, 8'h00);
      lacc(1'b1, ADDR_B0, 8'h00);
      check("restart err", 32'(err2), 32'h00000001);
      check("aborted", 32'(fault_if.busy), 32'h00000000);
      give_verdict();
   end
endmodule
`default_nettype wire
